/* src/tss_consts.svh */
/*
 * offsets, field positions, reset values and timing figures of the
 * touch scan sequencer. assumes a 100 MHz system clock.
 */
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH
`define TSS_CLK_NS      10
`define TSS_BOOT_MS     135
`define TSS_BOOT_MAX_MS 430
`define TSS_ACQ_MAX_MS  250
`define TSS_MS_NS       1000000
`define TSS_OFF_CTRL    8'h00
`define TSS_OFF_CMD     8'h04
`define TSS_OFF_IDLE    8'h08
`define TSS_OFF_ACTV    8'h0c
`define TSS_OFF_A2I     8'h10
`define TSS_OFF_LIMIT   8'h14
`define TSS_OFF_ACQ     8'h18
`define TSS_OFF_NTHR    8'h1c
`define TSS_OFF_GRIP    8'h20
`define TSS_OFF_STAT    8'h24
`define TSS_OFF_MASK    8'h28
`define TSS_OFF_STATE   8'h2c
`define TSS_OFF_TOUCH   8'h30
`define TSS_CTRL_SS     0
`define TSS_CTRL_NOISE  1
`define TSS_CTRL_SELF   2
`define TSS_CTRL_GRIP   3
`define TSS_CMD_RECAL   0
`define TSS_CMD_TUNE    1
`define TSS_ST_BOOT     0
`define TSS_ST_SIGNAL_TIMING_ERROR   1
`define TSS_ST_TOUCH    2
`define TSS_ST_MODE     3
`define TSS_RST_IDLE    8'h64
`define TSS_RST_ACTV    8'h10
`define TSS_RST_A2I     8'h32
`define TSS_RST_LIMIT   8'h03
`define TSS_RST_ACQ     8'h14
`define TSS_RST_NTHR    8'h80
`endif

/* src/tss_pkg.sv */
/*
 * types of the touch scan sequencer.
 * assumes tss_consts.svh is compiled alongside.
 */
`default_nettype none
package tss_pkg;
    typedef enum logic [1:0] {
        PH_BOOT  = 2'b00,
        PH_BURST = 2'b01,
        PH_SLEEP = 2'b10
    } tss_phase_t;
    typedef struct packed {
        logic grip_en;
        logic self_sched;
        logic host_noise;
        logic ss_en;
    } tss_ctrl_t;
    typedef struct packed {
        logic [1:0] ctrl;
        logic       active;
    } tss_noise_t;
endpackage
`default_nettype wire

/* src/tss_top.sv */
/*
 * touch scan sequencer: boot readiness, active/idle burst cycles,
 * per-node detection integrator, calibration and noise triggers,
 * spread spectrum, moisture and grip handling, axi4-lite registers.
 * assumes synchronous inputs from the analog front end on aclk.
 */
// Added by the designer: register access over AXI4-Lite and the address map.
`include "tss_consts.svh"
`default_nettype none
module tss_top import tss_pkg::*; #(
    parameter int NODES      = 16,
    parameter int BOOT_CYC   = `TSS_BOOT_MS * (`TSS_MS_NS / `TSS_CLK_NS),
    parameter int MS_CYC     = `TSS_MS_NS / `TSS_CLK_NS
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // axi4-lite slave
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // front end
    input  wire logic [NODES-1:0] node_over_thr,
    input  wire logic             self_touch,
    input  wire logic             moisture,
    input  wire logic [7:0]       noise_level,
    // outputs
    output logic                  message_pending_n,
    output logic                  irq,
    output logic                  active_mode,
    output logic                  burst_active,
    output logic [7:0]            burst_freq_sel,
    output logic                  calibrate,
    output tss_noise_t            noise_out,
    output logic [NODES-1:0]      touch_map
);
    localparam int NW = $clog2(NODES + 1);
    localparam logic [31:0] ACQ_MAX = 32'(`TSS_ACQ_MAX_MS);

    tss_phase_t       phase_reg;
    tss_ctrl_t        ctrl_reg;
    logic [7:0]       idle_reg, actv_reg, a2i_reg, limit_reg, acq_reg, nthr_reg;
    logic [NODES-1:0] grip_reg;
    logic [3:0]       stat_reg, mask_reg, stat_set;
    logic [31:0]      boot_cnt_reg, ms_div_reg;
    logic [7:0]       cyc_ms_reg, idle_cnt_reg;
    logic [NW-1:0]    node_idx_reg;
    logic             ms_tick, burst_end, cycle_end, any_touch;
    logic             cfg_cal, moist_cal_reg, moist_prev_reg;
    logic [NODES-1:0] touched, reported;
    logic [7:0]       integ [NODES];
    logic [1:0]       cmd_w;

    // axi write side: address and data taken in any order
    logic [7:0]  aw_reg;
    logic [31:0] w_reg;
    logic        aw_ok, w_ok, wr_go;
    assign wr_go = aw_ok & w_ok & ~s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok         <= 1'b0;
            w_ok          <= 1'b0;
            aw_reg        <= 8'h00;
            w_reg         <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            s_axi_awready <= ~aw_ok & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_ok & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok  <= 1'b1;
                aw_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok  <= 1'b1;
                w_reg <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_ok        <= 1'b0;
                w_ok         <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_reg > `TSS_OFF_MASK) ? 2'b10 : 2'b00;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // wstrb ignored: every field sits in the low byte lane except grip, which takes the low NODES bits
    function automatic logic hit(input logic [7:0] off);
        return wr_go && aw_reg == off;
    endfunction
    assign cmd_w = hit(`TSS_OFF_CMD) ? w_reg[1:0] : 2'b00;
    assign cfg_cal = hit(`TSS_OFF_LIMIT) | hit(`TSS_OFF_ACQ) | hit(`TSS_OFF_NTHR);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg  <= '0;
            idle_reg  <= `TSS_RST_IDLE;
            actv_reg  <= `TSS_RST_ACTV;
            a2i_reg   <= `TSS_RST_A2I;
            limit_reg <= `TSS_RST_LIMIT;
            acq_reg   <= `TSS_RST_ACQ;
            nthr_reg  <= `TSS_RST_NTHR;
            grip_reg  <= '0;
            mask_reg  <= 4'h0;
        end else begin
            if (hit(`TSS_OFF_CTRL)) ctrl_reg <= w_reg[3:0];
            if (hit(`TSS_OFF_IDLE)) idle_reg <= w_reg[7:0];
            if (hit(`TSS_OFF_ACTV)) actv_reg <= w_reg[7:0];
            if (hit(`TSS_OFF_A2I)) a2i_reg <= w_reg[7:0];
            if (hit(`TSS_OFF_LIMIT)) limit_reg <= w_reg[7:0];
            if (hit(`TSS_OFF_ACQ)) acq_reg <= w_reg[7:0];
            if (hit(`TSS_OFF_NTHR)) nthr_reg <= w_reg[7:0];
            if (hit(`TSS_OFF_GRIP)) grip_reg <= w_reg[NODES-1:0];
            if (hit(`TSS_OFF_MASK)) mask_reg <= w_reg[3:0];
        end
    end

    // sticky status, set beats write-one-to-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_reg <= 4'h0;
        end else begin
            stat_reg <= (stat_reg & ~(hit(`TSS_OFF_STAT) ? w_reg[3:0] : 4'h0)) | stat_set;
        end
    end

    // axi read side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                case (s_axi_araddr)
                    `TSS_OFF_CTRL:  s_axi_rdata <= {28'h0, ctrl_reg};
                    `TSS_OFF_CMD:   s_axi_rdata <= 32'h0;
                    `TSS_OFF_IDLE:  s_axi_rdata <= {24'h0, idle_reg};
                    `TSS_OFF_ACTV:  s_axi_rdata <= {24'h0, actv_reg};
                    `TSS_OFF_A2I:   s_axi_rdata <= {24'h0, a2i_reg};
                    `TSS_OFF_LIMIT: s_axi_rdata <= {24'h0, limit_reg};
                    `TSS_OFF_ACQ:   s_axi_rdata <= {24'h0, acq_reg};
                    `TSS_OFF_NTHR:  s_axi_rdata <= {24'h0, nthr_reg};
                    `TSS_OFF_GRIP:  s_axi_rdata <= 32'(grip_reg);
                    `TSS_OFF_STAT:  s_axi_rdata <= {28'h0, stat_reg};
                    `TSS_OFF_MASK:  s_axi_rdata <= {28'h0, mask_reg};
                    `TSS_OFF_STATE: s_axi_rdata <= {27'h0, noise_out, active_mode, moist_cal_reg};
                    `TSS_OFF_TOUCH: s_axi_rdata <= 32'(touch_map);
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // 1 ms enable from a divider
    assign ms_tick = (ms_div_reg == 32'(MS_CYC - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) ms_div_reg <= 32'h0;
        else ms_div_reg <= ms_tick ? 32'h0 : ms_div_reg + 32'h1;
    end

    // cycle sequencing: boot, burst over all nodes, sleep
    assign burst_end = (phase_reg == PH_BURST) && node_idx_reg == NW'(NODES - 1);
    assign cycle_end = (phase_reg == PH_SLEEP) && ms_tick &&
                       cyc_ms_reg + 8'h1 >= (active_mode ? actv_reg : idle_reg);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_reg    <= PH_BOOT;
            boot_cnt_reg <= 32'h0;
            node_idx_reg <= '0;
            cyc_ms_reg   <= 8'h0;
            burst_active <= 1'b0;
        end else begin
            if (phase_reg == PH_BURST && ms_tick) cyc_ms_reg <= cyc_ms_reg + 8'h1;
            case (phase_reg)
                PH_BOOT: begin
                    boot_cnt_reg <= boot_cnt_reg + 32'h1;
                    if (boot_cnt_reg == 32'(BOOT_CYC - 1)) begin
                        phase_reg    <= PH_BURST;
                        burst_active <= 1'b1;
                    end
                end
                PH_BURST: begin
                    node_idx_reg <= node_idx_reg + NW'(1);
                    if (burst_end) begin
                        phase_reg    <= PH_SLEEP;
                        burst_active <= 1'b0;
                        node_idx_reg <= '0;
                    end
                end
                PH_SLEEP: begin
                    if (ms_tick) cyc_ms_reg <= cyc_ms_reg + 8'h1;
                    if (cycle_end) begin
                        phase_reg    <= PH_BURST;
                        burst_active <= 1'b1;
                        cyc_ms_reg   <= 8'h0;
                    end
                end
                default: phase_reg <= PH_BOOT;
            endcase
        end
    end

    // per-node detection integrator, updated once per acquisition
    for (genvar n = 0; n < NODES; n++) begin : g_integ
        always_ff @(posedge aclk) begin
            if (!aresetn || calibrate) begin
                integ[n] <= 8'h0;
            end else if (burst_end) begin
                if (!node_over_thr[n]) integ[n] <= 8'h0;
                else if (integ[n] < limit_reg) integ[n] <= integ[n] + 8'h1;
            end
        end
        assign touched[n] = (limit_reg != 8'h0) && integ[n] >= limit_reg;
    end

    // mutual first; self catches a lone touch, or counts alongside mutual while wet
    assign reported = touched & ~(ctrl_reg.grip_en ? grip_reg : '0);
    assign any_touch = (|reported) || (ctrl_reg.self_sched && self_touch &&
                       (moisture || ~|touched));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            touch_map    <= '0;
            active_mode  <= 1'b0;
            idle_cnt_reg <= 8'h0;
        end else if (cycle_end) begin
            touch_map <= reported;
            if (any_touch) begin
                active_mode  <= 1'b1;
                idle_cnt_reg <= 8'h0;
            end else if (idle_cnt_reg + 8'h1 >= a2i_reg) begin
                active_mode  <= 1'b0;
            end else begin
                idle_cnt_reg <= idle_cnt_reg + 8'h1;
            end
        end
    end

    // status events
    always_comb begin
        stat_set = 4'h0;
        stat_set[`TSS_ST_BOOT]   = phase_reg == PH_BOOT && boot_cnt_reg == 32'(BOOT_CYC - 1);
        stat_set[`TSS_ST_SIGNAL_TIMING_ERROR] = burst_end && 32'(acq_reg) > ACQ_MAX;
        stat_set[`TSS_ST_TOUCH]  = cycle_end && reported != touch_map;
        stat_set[`TSS_ST_MODE]   = cycle_end && (any_touch != active_mode);
    end

    // pending line held high through boot, low once ready or a message waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            message_pending_n <= 1'b1;
            irq               <= 1'b0;
        end else begin
            message_pending_n <= ~|stat_reg;
            irq               <= |(stat_reg & mask_reg);
        end
    end

    // calibration triggers; moisture included in a calibration is remembered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            calibrate      <= 1'b0;
            moist_cal_reg  <= 1'b0;
            moist_prev_reg <= 1'b0;
        end else begin
            moist_prev_reg <= moisture;
            calibrate <= cmd_w[`TSS_CMD_RECAL] | cmd_w[`TSS_CMD_TUNE] | cfg_cal |
                         (moist_cal_reg & moist_prev_reg & ~moisture);
            if (calibrate) moist_cal_reg <= moisture;
            else if (!moisture) moist_cal_reg <= 1'b0;
        end
    end

    // noise suppression: host flag or internal measurement above threshold
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            noise_out <= '0;
        end else begin
            noise_out.active <= ctrl_reg.host_noise | (noise_level > nthr_reg);
            noise_out.ctrl   <= (noise_level > nthr_reg) ? noise_level[7:6] :
                                {1'b0, ctrl_reg.host_noise};
        end
    end

    // lfsr steps on every measurement pulse; fixed frequency otherwise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            burst_freq_sel <= 8'h01;
        end else if (phase_reg == PH_BURST && ctrl_reg.ss_en) begin
            burst_freq_sel <= {burst_freq_sel[6:0],
                burst_freq_sel[7] ^ burst_freq_sel[5] ^ burst_freq_sel[4] ^ burst_freq_sel[3]};
        end else if (!ctrl_reg.ss_en) begin
            burst_freq_sel <= 8'h01;
        end
    end

    // checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    boot_ready_a: assert property (stat_set[`TSS_ST_BOOT] |=> ##1 !message_pending_n)
        else $error("pending line not low after boot");
    boot_quiet_a: assert property (phase_reg == PH_BOOT |-> message_pending_n)
        else $error("pending line low during boot");
    burst_len_a: assert property ($rose(burst_active) |-> burst_active [*2])
        else $error("burst too short");
    integ_clr_a: assert property (burst_end && !node_over_thr[0] |=> integ[0] == 8'h0)
        else $error("integrator not cleared");
    integ_inc_a: assert property (burst_end && node_over_thr[0] && integ[0] < limit_reg
        && !calibrate |=> integ[0] == $past(integ[0]) + 8'h1)
        else $error("integrator not counted");
    sig_err_a: assert property (burst_end && acq_reg > 8'(`TSS_ACQ_MAX_MS)
        |=> stat_reg[`TSS_ST_SIGNAL_TIMING_ERROR])
        else $error("timing error not flagged");
    recal_a: assert property (cmd_w[`TSS_CMD_RECAL] |=> calibrate)
        else $error("recalibrate ignored");
    host_noise_a: assert property (ctrl_reg.host_noise ##1 ctrl_reg.host_noise
        |-> noise_out.active)
        else $error("noise flag ignored");
    wake_a: assert property (cycle_end && any_touch |=> active_mode)
        else $error("no return to active");
    grip_a: assert property (cycle_end && ctrl_reg.grip_en |=> (touch_map & grip_reg) == '0)
        else $error("edge touch reported");
    ss_a: assert property (burst_active && ctrl_reg.ss_en && phase_reg == PH_BURST
        |=> burst_freq_sel != $past(burst_freq_sel))
        else $error("burst frequency held");
    idle_c: cover property (cycle_end && !any_touch && active_mode ##1 !active_mode);
    touch_c: cover property (stat_set[`TSS_ST_TOUCH]);
    moist_c: cover property (moist_cal_reg ##1 !moisture ##1 calibrate);
endmodule
`default_nettype wire

/* test/tss_host_model.sv */
/* host side of the message line: pulled-up line, never driven by the host.
   assumes the aclk domain of the sequencer. */
`default_nettype none
module tss_host_model (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // message line
    input  wire logic message_pending_n,
    // observation
    output logic      ready_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // undriven by the host, so only the device pulls it low
    wire logic line_level = (message_pending_n === 1'b0) ? 1'b0 : 1'b1;
    always @(posedge aclk) begin
        if (!aresetn) ready_seen <= 1'b0;
        else if (line_level == 1'b0) ready_seen <= 1'b1;
    end
endmodule
`default_nettype wire

/* test/tss_top_test.sv */
/* self-checking bench of the sequencer: axi4-lite master, front end stimulus.
   assumes tss_top, tss_pkg and tss_host_model compiled first. */
`include "tss_consts.svh"
`default_nettype none
module tss_top_test import tss_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NB = 16;
    localparam int MSC = 20;
    localparam int BOOTC = 50;
    logic          aclk = 0, aresetn = 0, self_touch = 0, moisture = 0;
    logic [7:0]    awaddr = 0, araddr = 0, noise_level = 0, f0;
    logic [31:0]   wdata = 0, rdata;
    logic          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [NB-1:0] node_over_thr = 0, touch_map, p, m;
    logic          awready, wready, bvalid, arready, rvalid, ready_seen;
    logic [1:0]    bresp, rresp;
    logic          mpn, irq, active_mode, burst_active, calibrate;
    logic [7:0]    freq;
    tss_noise_t    noise_out;
    int            fails = 0, check_count = 0, cal_seen = 0;
    logic [15:0]   lfsr_state = 16'h000f;
    logic [7:0]    roffs[6] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
    logic [7:0]    rexp[6] = '{`TSS_RST_IDLE, `TSS_RST_ACTV, `TSS_RST_A2I,
                               `TSS_RST_LIMIT, `TSS_RST_ACQ, `TSS_RST_NTHR};
    logic [7:0]    coffs[6] = '{8'h14, 8'h18, 8'h1c, 8'h04, 8'h04, 8'h00};
    logic [7:0]    cdat[6] = '{8'h03, 8'h14, 8'h80, 8'h01, 8'h02, 8'h00};
    int            cexp[6] = '{1, 1, 1, 1, 1, 0};
    tss_top #(.NODES(NB), .BOOT_CYC(BOOTC), .MS_CYC(MSC)) tss_top_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .node_over_thr(node_over_thr), .self_touch(self_touch), .moisture(moisture),
        .noise_level(noise_level), .message_pending_n(mpn), .irq(irq),
        .active_mode(active_mode), .burst_active(burst_active), .burst_freq_sel(freq),
        .calibrate(calibrate), .noise_out(noise_out), .touch_map(touch_map));
    tss_host_model tss_host_model_inst (.aclk(aclk), .aresetn(aresetn),
        .message_pending_n(mpn), .ready_seen(ready_seen));
    initial forever #5 aclk = ~aclk;
    // pulses are one cycle wide, so a pre-edge sample counts each once
    always @(posedge aclk) if (calibrate === 1'b1) cal_seen++;
    function automatic logic [15:0] lfsr();
        lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13]
                      ^ lfsr_state[12] ^ lfsr_state[10]};
        return lfsr_state;
    endfunction
    function automatic logic [NB-1:0] exp_touch(input logic [NB-1:0] t, k, input logic g);
        return g ? (t & ~k) : t;
    endfunction
    function automatic tss_noise_t exp_noise(input logic [7:0] lv, thr, input logic h);
        return (lv > thr) ? tss_noise_t'({lv[7:6], 1'b1}) : tss_noise_t'({1'b0, h, h});
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic fail_out();
        fails++;
        $display("[ERR] wait expected done seen timeout");
        tally_and_finish();
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // sel 1 watches burst_active, 0 the pending line; no ref, so values stay live
    task automatic wait_sig(input logic sel, input logic v, output int n);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (n > 5000) fail_out();
        end while ((sel ? burst_active : mpn) !== v);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (n > 100) fail_out();
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
        @(posedge aclk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
            if (n > 100) fail_out();
        end while (rvalid !== 1'b1);
        chk("rdata", rdata, exp);
        chk("rresp", 32'(rresp), 32'(er));
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // entered two edges into a burst; leaves two edges into the next one
    task automatic acq(input logic [NB-1:0] t, output int per);
        int n;
        int k;
        node_over_thr <= t;
        wait_sig(1'b1, 1'b0, n);
        wait_sig(1'b1, 1'b1, k);
        per = (n + k + 2 + MSC / 2) / MSC;
        repeat (2) @(posedge aclk);
    endtask
    initial begin
        int n;
        int per;
        int c0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("reset_lines", {mpn, irq, active_mode, freq}, {3'b100, 8'h01});
        wait_sig(1'b0, 1'b0, n);
        chk("boot_time", 32'(n >= BOOTC && n <= BOOTC + 4), 32'h1);
        // host model registers what it saw, so give it one edge
        @(posedge aclk);
        chk("host_ready", 32'(ready_seen), 32'h1);
        for (int i = 0; i < 6; i++) rchk(roffs[i], 32'(rexp[i]), 2'b00);
        rchk(8'h24, 32'h1, 2'b00);
        wr(8'h24, 32'hf, 2'b00);
        repeat (2) @(posedge aclk);
        chk("mpn_clear", 32'(mpn), 32'h1);
        rchk(8'h40, 32'h0, 2'b10);
        wr(8'h2c, 32'h1, 2'b10);
        for (int i = 0; i < 6; i++) begin
            c0 = cal_seen;
            wr(coffs[i], 32'(cdat[i]), 2'b00);
            repeat (2) @(posedge aclk);
            chk("cal", 32'(cal_seen - c0), 32'(cexp[i]));
        end
        wr(8'h08, 32'h4, 2'b00);
        wr(8'h0c, 32'h2, 2'b00);
        wr(8'h10, 32'h2, 2'b00);
        wait_sig(1'b1, 1'b1, n);
        repeat (2) @(posedge aclk);
        acq(0, per);
        acq(0, per);
        chk("idle_period", 32'(per), 32'h4);
        p = lfsr() | 16'h0001;
        for (int i = 0; i < 6; i++) begin
            acq((i == 2) ? '0 : p, per);
            chk("touch_map", 32'(touch_map), 32'((i == 5) ? p : '0));
        end
        chk("active", 32'(active_mode), 32'h1);
        acq(p, per);
        chk("active_period", 32'(per), 32'h2);
        m = lfsr();
        wr(8'h20, 32'(m), 2'b00);
        wr(8'h00, 32'h8, 2'b00);
        acq(p, per);
        chk("grip", 32'(touch_map), 32'(exp_touch(p, m, 1'b1)));
        acq(0, per);
        acq(0, per);
        chk("idle_again", 32'(active_mode), 32'h0);
        wr(8'h28, 32'h2, 2'b00);
        wr(8'h18, 32'd251, 2'b00);
        wr(8'h24, 32'hf, 2'b00);
        acq(0, per);
        chk("signal_timing_error_irq", 32'(irq), 32'h1);
        wr(8'h28, 32'h0, 2'b00);
        repeat (2) @(posedge aclk);
        chk("irq_masked", 32'(irq), 32'h0);
        wr(8'h18, 32'd250, 2'b00);
        acq(0, per);
        wr(8'h24, 32'hf, 2'b00);
        acq(0, per);
        rchk(8'h24, 32'h0, 2'b00);
        moisture <= 1'b1;
        acq(0, per);
        c0 = cal_seen;
        wr(8'h04, 32'h1, 2'b00);
        moisture <= 1'b0;
        acq(0, per);
        chk("moist_gone", 32'(cal_seen - c0), 32'h2);
        wr(8'h00, 32'h2, 2'b00);
        acq(0, per);
        chk("host_noise", 32'(noise_out), 32'(exp_noise(8'h00, 8'h80, 1'b1)));
        wr(8'h00, 32'h0, 2'b00);
        for (int i = 0; i < 4; i++) begin
            f0 = (i == 0) ? 8'h80 : (i == 1) ? 8'hc1 : 8'(lfsr());
            noise_level <= f0;
            acq(0, per);
            chk("noise", 32'(noise_out), 32'(exp_noise(f0, 8'h80, 1'b0)));
        end
        wr(8'h00, 32'h4, 2'b00);
        self_touch <= 1'b1;
        acq(0, per);
        chk("self_wake", 32'(active_mode), 32'h1);
        self_touch <= 1'b0;
        wr(8'h00, 32'h1, 2'b00);
        acq(0, per);
        f0 = freq;
        @(posedge aclk);
        chk("ss_step", 32'(freq !== f0), 32'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
